// >>> hdl/lmr_pkg.sv
// Shared constants of the line monitor register group: offsets, fields,
// reset values and widths.
// Assumes a byte-wide register port with 8-bit addresses.
package lmr_pkg;

  // Register offsets on the byte register port
  localparam logic [7:0] OFS_LOW_BATTERY    = 8'h4B;
  localparam logic [7:0] OFS_POWER_SELECT   = 8'h4C;
  localparam logic [7:0] OFS_POWER_READING  = 8'h4D;
  localparam logic [7:0] OFS_LOOP_VOLTAGE   = 8'h4E;
  localparam logic [7:0] OFS_LOOP_CURRENT   = 8'h4F;
  localparam logic [7:0] OFS_TIP_VOLTAGE    = 8'h50;

  // Field widths and positions
  localparam int         BATTERY_W          = 6;   // Battery code width
  localparam int         SELECT_W           = 3;   // Transistor selector
  localparam int         MAG_W              = 6;   // Loop magnitude fields
  localparam int         SIGN_BIT           = 6;   // Polarity bit position
  localparam int         DATA_W             = 8;   // Register data width
  localparam int         NUM_TRANSISTORS    = 6;   // Line-drive transistors

  // Reset values: low battery -24 V at 1.5 V per code is code 16
  localparam logic [5:0] LOW_BATTERY_RST    = 6'h10;
  localparam logic [2:0] POWER_SELECT_RST   = 3'h0;
  localparam logic [7:0] READ_ZERO          = 8'h00;

  // Selector codes of the low-power transistors three and four
  localparam logic [2:0] SEL_Q3             = 3'h2;
  localparam logic [2:0] SEL_Q4             = 3'h3;
  // Highest defined selector code (transistor six)
  localparam logic [2:0] SEL_LAST           = 3'h5;

endpackage : lmr_pkg

// >>> hdl/lmr_power_sel.sv
// Power monitor path: synchronises the per-transistor power words and
// picks the one named by the selector.
// Assumes the power words come from the analog monitor, asynchronous
// to i_mclk, and the selector comes from logic on i_mclk.
`timescale 1ns/1ps
`default_nettype none

module lmr_power_sel #(
  parameter int NUM_Q = lmr_pkg::NUM_TRANSISTORS,  // Transistor count
  parameter int WORD  = lmr_pkg::DATA_W            // Power word width
) (
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst,
  input  wire logic [2:0]            i_select,
  input  wire logic [NUM_Q*WORD-1:0] i_q_power,
  output logic      [WORD-1:0]       o_power_reading,
  output logic                       o_small_range
);

  // Selector has three bits, so no more than eight transistors
  if (NUM_Q < 1 || NUM_Q > 8 || WORD != 8) begin : g_bad_param
    $error("lmr_power_sel: unsupported NUM_Q or WORD");
  end

  wire logic [NUM_Q*WORD-1:0] sync_word;  // Second sync stages, side by side
  logic [WORD-1:0]            pick;       // Selected word before register
  logic                       sel_valid;  // Selector names a fitted one

  // Two-stage synchroniser, one lane per transistor; each lane owns
  // its flops so that no register has more than one process
  genvar g;
  generate
    for (g = 0; g < NUM_Q; g++) begin : g_sync
      logic [WORD-1:0] meta_r;  // First stage, read by sync_r only
      logic [WORD-1:0] sync_r;  // Second stage
      // A multi-bit word may tear for one sample; the value is a
      // slowly moving measurement, so one odd sample is acceptable
      always_ff @(posedge i_mclk) begin
        if (i_rst) begin
          meta_r <= '0;
          sync_r <= '0;
        end else begin
          meta_r <= i_q_power[g*WORD +: WORD];
          sync_r <= meta_r;
        end
      end
      assign sync_word[g*WORD +: WORD] = sync_r;
    end
  endgenerate

  // Codes above the last transistor have no source; read them as zero
  assign sel_valid = (i_select <= lmr_pkg::SEL_LAST) &&
                     (32'(i_select) < NUM_Q);                       // R3
  assign pick      = sel_valid ? sync_word[i_select*WORD +: WORD]
                               : lmr_pkg::READ_ZERO;                // R4

  // Q3 and Q4 report on the 3.62 mW scale, the rest on 30.4 mW
  assign o_small_range = (i_select == lmr_pkg::SEL_Q3) ||
                         (i_select == lmr_pkg::SEL_Q4);          // R5 R6

  // Registered reading of the selected transistor
  always_ff @(posedge i_mclk) begin
    if (i_rst) o_power_reading <= lmr_pkg::READ_ZERO;
    else       o_power_reading <= pick;                             // R4
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  a_undef_select_zero: assert property (                            // R3
    (i_select > lmr_pkg::SEL_LAST) |=> (o_power_reading == 8'h00))
    else $error("undefined selector did not read zero");

  a_power_follows_select: assert property (                         // R4
    (i_select == 3'h1) |=> (o_power_reading == $past(sync_word[15:8])))
    else $error("power reading not from selected transistor");

  a_scale_flag: assert property (                                // R5 R6
    o_small_range == (i_select == 3'h2 || i_select == 3'h3))
    else $error("power scale flag wrong for selector");

endmodule // lmr_power_sel

`default_nettype wire

// >>> hdl/lmr_regs.sv
// Line monitor register group: low battery setting, power monitor
// selector and reading, loop voltage, loop current and TIP sense.
// Assumes a byte register port on i_mclk and sense codes that arrive
// from the analog side, asynchronous to i_mclk.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [R1] Low battery 6-bit code, default -24 V
// [R2] Software keeps high battery at least low
// [R3] Selector 0-5 picks transistor, 6-7 undefined
// [R4] Power register shows selected transistor's power
// [R5] Q1 Q2 Q5 Q6 use 30.4 mW steps
// [R6] Q3 Q4 use 3.62 mW steps
// [R7] Loop voltage sign bit 6: 1 if TIP<RING
// [R8] Loop voltage magnitude 6 bits, 1.5 V steps
// [R9] Loop current sign bit 6: 1 if reverse
// [R10] Loop current magnitude 6 bits, 1.27 mA steps
// [R11] TIP sense 8 bits, 0.376 V steps
// [R12] Writes to read-only registers change nothing
module lmr_regs #(
  parameter int NUM_Q = lmr_pkg::NUM_TRANSISTORS  // Fitted transistors
) (
  input  wire logic                i_mclk,
  input  wire logic                i_rst,
  // Byte register port
  input  wire logic [7:0]          i_addr,
  input  wire logic                i_wr_en,
  input  wire logic [7:0]          i_wdata,
  input  wire logic                i_rd_en,
  output logic      [7:0]          o_rdata,
  output logic                     o_rdata_valid,
  // Analog sense codes, asynchronous
  input  wire logic                i_tip_below_ring,
  input  wire logic [5:0]          i_loop_voltage_magnitude,
  input  wire logic                i_loop_current_reverse,
  input  wire logic [5:0]          i_loop_current_magnitude,
  input  wire logic [7:0]          i_tip_voltage_field,
  input  wire logic [NUM_Q*8-1:0]  i_q_power,
  // High battery code from the neighbouring register, same clock
  input  wire logic [5:0]          i_high_battery_code,
  // Settings to the analog side
  output logic      [5:0]          o_low_battery_code,
  output logic      [2:0]          o_power_select_field,
  output logic                     o_power_small_range,
  output logic                     o_battery_order_fault
);

  // Selector and data path are built for six transistors at most
  if (NUM_Q < 1 || NUM_Q > lmr_pkg::NUM_TRANSISTORS) begin : g_bad_param
    $error("lmr_regs: NUM_Q out of range");
  end

  localparam int SENSE_W = 22;  // 1+6+1+6+8 bits of line sense

  // Settings held by software
  logic [5:0]         low_battery_r;     // Low battery code
  logic [5:0]         low_battery_nxt;
  logic [2:0]         power_select_r;    // Transistor selector
  logic [2:0]         power_select_nxt;
  // Sense synchroniser; meta stage feeds only the sync stage
  logic [SENSE_W-1:0] sense_meta_r;
  logic [SENSE_W-1:0] sense_r;
  logic [7:0]         power_reading;     // Selected power from the path
  logic [7:0]         rdata_nxt;

  // Field views of the synchronised sense bundle
  logic               loop_voltage_sign;
  logic [5:0]         loop_voltage_magnitude;
  logic               loop_current_sign;
  logic [5:0]         loop_current_magnitude;
  logic [7:0]         tip_voltage_field;

  // Address decode, one wire per register
  logic hit_low, hit_sel, hit_pwr, hit_lv, hit_lc, hit_tip;
  logic wr_low, wr_sel, wr_ro;

  assign hit_low = (i_addr == lmr_pkg::OFS_LOW_BATTERY);
  assign hit_sel = (i_addr == lmr_pkg::OFS_POWER_SELECT);
  assign hit_pwr = (i_addr == lmr_pkg::OFS_POWER_READING);
  assign hit_lv  = (i_addr == lmr_pkg::OFS_LOOP_VOLTAGE);
  assign hit_lc  = (i_addr == lmr_pkg::OFS_LOOP_CURRENT);
  assign hit_tip = (i_addr == lmr_pkg::OFS_TIP_VOLTAGE);

  // Only the two settings accept writes; read-only hits are dropped
  assign wr_low = i_wr_en && hit_low;                               // R1
  assign wr_sel = i_wr_en && hit_sel;                               // R3
  assign wr_ro  = i_wr_en && (hit_pwr || hit_lv || hit_lc || hit_tip); // R12

  // Next values of the settings; reserved upper bits are not stored
  assign low_battery_nxt  = wr_low ? i_wdata[5:0] : low_battery_r;  // R1
  assign power_select_nxt = wr_sel ? i_wdata[2:0] : power_select_r;

  // Settings registers
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      low_battery_r  <= lmr_pkg::LOW_BATTERY_RST;                   // R1
      power_select_r <= lmr_pkg::POWER_SELECT_RST;
    end else begin
      low_battery_r  <= low_battery_nxt;
      power_select_r <= power_select_nxt;
    end
  end

  // Two-stage synchroniser for the line sense codes; a word may tear
  // for one sample, which a moving measurement tolerates
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sense_meta_r <= '0;
      sense_r      <= '0;
    end else begin
      sense_meta_r <= {i_tip_below_ring, i_loop_voltage_magnitude,
                       i_loop_current_reverse, i_loop_current_magnitude,
                       i_tip_voltage_field};
      sense_r      <= sense_meta_r;
    end
  end

  // Unpack the sense bundle; the read path never writes these
  assign loop_voltage_sign      = sense_r[21];                      // R7
  assign loop_voltage_magnitude = sense_r[20:15];                   // R8
  assign loop_current_sign      = sense_r[14];                      // R9
  assign loop_current_magnitude = sense_r[13:8];                   // R10
  assign tip_voltage_field      = sense_r[7:0];                    // R11

  // Power monitor path: selection and the scale flag
  lmr_power_sel #(
    .NUM_Q           (NUM_Q),
    .WORD            (lmr_pkg::DATA_W)
  ) u_power_sel (
    .i_mclk          (i_mclk),
    .i_rst           (i_rst),
    .i_select        (power_select_r),
    .i_q_power       (i_q_power),
    .o_power_reading (power_reading),
    .o_small_range   (o_power_small_range)
  );

  // Read mux; reserved bits and unmapped addresses read zero
  always_comb begin
    rdata_nxt = lmr_pkg::READ_ZERO;
    if (hit_low) begin
      rdata_nxt = {2'h0, low_battery_r};                            // R1
    end else if (hit_sel) begin
      rdata_nxt = {5'h00, power_select_r};
    end else if (hit_pwr) begin
      rdata_nxt = power_reading;                                    // R4
    end else if (hit_lv) begin
      rdata_nxt = {1'h0, loop_voltage_sign, loop_voltage_magnitude};
    end else if (hit_lc) begin
      rdata_nxt = {1'h0, loop_current_sign, loop_current_magnitude};
    end else if (hit_tip) begin
      rdata_nxt = tip_voltage_field;                               // R11
    end
  end

  // Read data is captured one cycle after the read strobe
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rdata       <= lmr_pkg::READ_ZERO;
      o_rdata_valid <= 1'b0;
    end else begin
      o_rdata_valid <= i_rd_en;
      if (i_rd_en) o_rdata <= rdata_nxt;
    end
  end

  // Settings drive the analog side directly
  assign o_low_battery_code   = low_battery_r;                      // R1
  assign o_power_select_field = power_select_r;                     // R3

  // Software must keep high battery no lower than low battery; the
  // device only flags a violation, it does not correct it
  assign o_battery_order_fault = (i_high_battery_code < low_battery_r);//R2

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  // A read strobe at a given register
  sequence s_read(logic [7:0] ofs);
    i_rd_en && (i_addr == ofs);
  endsequence

  // A write strobe at a given register
  sequence s_write(logic [7:0] ofs);
    i_wr_en && (i_addr == ofs);
  endsequence

  a_low_bat_write: assert property (                                // R1
    s_write(lmr_pkg::OFS_LOW_BATTERY) ##1 !i_wr_en
    ##1 s_read(lmr_pkg::OFS_LOW_BATTERY)
    |=> o_rdata_valid && (o_rdata == {2'h0, $past(i_wdata[5:0], 3)}))
    else $error("low battery code did not read back written value");

  a_low_bat_reset: assert property (                                // R1
    $fell(i_rst) |-> (o_low_battery_code == 6'h10))
    else $error("low battery code not at default after reset");

  a_select_drive: assert property (                                 // R3
    s_write(lmr_pkg::OFS_POWER_SELECT)
    |=> (o_power_select_field == $past(i_wdata[2:0])))
    else $error("selector write not applied");

  a_power_read: assert property (                                   // R4
    s_read(lmr_pkg::OFS_POWER_READING)
    |=> (o_rdata == $past(power_reading)))
    else $error("power read does not show selected reading");

  a_lv_sign: assert property (                                   // R7 R8
    s_read(lmr_pkg::OFS_LOOP_VOLTAGE)
    |=> (o_rdata[7] == 1'b0) && (o_rdata[6] == $past(sense_r[21]))
        && (o_rdata[5:0] == $past(sense_r[20:15])))
    else $error("loop voltage fields wrong");

  a_lc_fields: assert property (                                // R9 R10
    s_read(lmr_pkg::OFS_LOOP_CURRENT)
    |=> (o_rdata == {1'b0, $past(sense_r[14:8])}))
    else $error("loop current fields wrong");

  a_tip_sense: assert property (                                   // R11
    s_read(lmr_pkg::OFS_TIP_VOLTAGE)
    |=> (o_rdata == $past(sense_r[7:0])))
    else $error("TIP sense read wrong");

  a_ro_write_inert: assert property (                              // R12
    wr_ro |=> $stable(low_battery_r) && $stable(power_select_r))
    else $error("write to read-only register changed a setting");

  a_sense_pipeline: assert property (                         // R11 (TIP field)
    (!i_rst && $stable(i_tip_voltage_field)) [*3]
    |-> (sense_r[7:0] == $past(i_tip_voltage_field, 2)))
    else $error("TIP sense did not settle in two stages");

endmodule // lmr_regs

`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the line monitor register group: drives the
// byte register port and the sense inputs, compares read-back values.
// Assumes lmr_pkg is compiled first and lmr_regs is the top design.
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int NQ = lmr_pkg::NUM_TRANSISTORS;  // Fitted transistors

  logic          i_mclk;                      // 250 MHz clock
  logic          i_rst;                       // Synchronous reset
  logic [7:0]    i_addr;                      // Register offset
  logic          i_wr_en;                     // Write strobe
  logic [7:0]    i_wdata;                     // Write data
  logic          i_rd_en;                     // Read strobe
  logic [7:0]    o_rdata;                     // Read data
  logic          o_rdata_valid;               // Read answer pulse
  logic          i_tip_below_ring;            // Loop voltage sign in
  logic [5:0]    i_loop_voltage_magnitude;    // Loop voltage code in
  logic          i_loop_current_reverse;      // Loop current sign in
  logic [5:0]    i_loop_current_magnitude;    // Loop current code in
  logic [7:0]    i_tip_voltage_field;         // TIP sense code in
  logic [NQ*8-1:0] i_q_power;                 // Per-transistor power
  logic [5:0]    i_high_battery_code;         // Neighbour's setting
  logic [5:0]    o_low_battery_code;          // Low battery to analog
  logic [2:0]    o_power_select_field;        // Selector to analog
  logic          o_power_small_range;         // Fine power scale flag
  logic          o_battery_order_fault;       // High below low
  int            fails;                       // Mismatch count
  int            tests_run;                   // Comparison count
  logic [7:0]    d;                           // Last read value

  lmr_regs #(.NUM_Q(NQ)) i_dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wr_en(i_wr_en),
    .i_wdata(i_wdata), .i_rd_en(i_rd_en), .o_rdata(o_rdata),
    .o_rdata_valid(o_rdata_valid), .i_tip_below_ring(i_tip_below_ring),
    .i_loop_voltage_magnitude(i_loop_voltage_magnitude),
    .i_loop_current_reverse(i_loop_current_reverse),
    .i_loop_current_magnitude(i_loop_current_magnitude),
    .i_tip_voltage_field(i_tip_voltage_field), .i_q_power(i_q_power),
    .i_high_battery_code(i_high_battery_code),
    .o_low_battery_code(o_low_battery_code),
    .o_power_select_field(o_power_select_field),
    .o_power_small_range(o_power_small_range),
    .o_battery_order_fault(o_battery_order_fault)
  );

  // Free-running clock, 4 ns period
  always #2 i_mclk = ~i_mclk;

  // Verdict and end of run; the only place the run stops
  task automatic end_sim();
    if (fails == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Compare one byte, four-state exact
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One write; strobe launched after an edge, dropped at the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    i_addr  <= a;
    i_wdata <= v;
    i_wr_en <= 1'b1;
    @(posedge i_mclk);
    i_wr_en <= 1'b0;
  endtask

  // One read; the answer is awaited under a small bound
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    int n;
    @(posedge i_mclk);
    i_addr  <= a;
    i_rd_en <= 1'b1;
    @(posedge i_mclk);
    i_rd_en <= 1'b0;
    #1;
    for (n = 0; n < 4 && o_rdata_valid !== 1'b1; n++) begin
      @(posedge i_mclk);
      #1;
    end
    if (n == 4) begin
      fails++;
      end_sim();
    end
    v = o_rdata;
  endtask

  // Apply sense codes, let the synchronisers settle, poke and read
  task automatic sense(input logic vs, input logic [5:0] vm,
                       input logic cs, input logic [5:0] cm,
                       input logic [7:0] tv);
    logic [7:0] r;
    @(posedge i_mclk);
    i_tip_below_ring         <= vs;
    i_loop_voltage_magnitude <= vm;
    i_loop_current_reverse   <= cs;
    i_loop_current_magnitude <= cm;
    i_tip_voltage_field      <= tv;
    repeat (4) @(posedge i_mclk);
    // Writes to read-only places must not disturb the reported codes
    wr(lmr_pkg::OFS_LOOP_VOLTAGE, 8'hFF);
    wr(lmr_pkg::OFS_TIP_VOLTAGE, ~tv);
    rd(lmr_pkg::OFS_LOOP_VOLTAGE, r);
    check(r, {1'b0, vs, vm});
    rd(lmr_pkg::OFS_LOOP_CURRENT, r);
    check(r, {1'b0, cs, cm});
    rd(lmr_pkg::OFS_TIP_VOLTAGE, r);
    check(r, tv);
  endtask

  // Main sequence
  initial begin
    i_mclk = 1'b0;
    i_rst = 1'b1;
    i_addr = 8'h00;
    i_wr_en = 1'b0;
    i_wdata = 8'h00;
    i_rd_en = 1'b0;
    i_tip_below_ring = 1'b0;
    i_loop_voltage_magnitude = 6'h00;
    i_loop_current_reverse = 1'b0;
    i_loop_current_magnitude = 6'h00;
    i_tip_voltage_field = 8'h00;
    i_high_battery_code = 6'h32;
    fails = 0;
    tests_run = 0;
    // Distinct power code per transistor, so a wrong pick shows
    for (int k = 0; k < NQ; k++) begin
      i_q_power[k*8 +: 8] = 8'hC1 + 8'(k);
    end
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    #1;
    check({2'h0, o_low_battery_code}, 8'h10);
    check({7'h00, o_rdata_valid}, 8'h00);
    rd(lmr_pkg::OFS_LOW_BATTERY, d);
    check(d, 8'h10);
    rd(lmr_pkg::OFS_POWER_SELECT, d);
    check(d, 8'h00);
    // Full-scale code keeps only six bits; reserved bits read zero
    wr(lmr_pkg::OFS_LOW_BATTERY, 8'hFF);
    rd(lmr_pkg::OFS_LOW_BATTERY, d);
    check(d, 8'h3F);
    // Low above high must be flagged, equal must not
    check({7'h00, o_battery_order_fault}, 8'h01);
    wr(lmr_pkg::OFS_LOW_BATTERY, 8'h32);
    #1;
    check({7'h00, o_battery_order_fault}, 8'h00);
    wr(lmr_pkg::OFS_LOW_BATTERY, 8'h00);
    rd(lmr_pkg::OFS_LOW_BATTERY, d);
    check(d, 8'h00);
    // Every selector code, defined and undefined
    for (int s = 0; s < 8; s++) begin
      wr(lmr_pkg::OFS_POWER_SELECT, 8'hF8 | 8'(s));
      repeat (3) @(posedge i_mclk);
      #1;
      check({7'h00, o_power_small_range},
            (s == 2 || s == 3) ? 8'h01 : 8'h00);
      check({5'h00, o_power_select_field}, 8'(s));
      rd(lmr_pkg::OFS_POWER_SELECT, d);
      check(d, 8'(s));
      rd(lmr_pkg::OFS_POWER_READING, d);
      check(d, (s < NQ) ? 8'hC1 + 8'(s) : 8'h00);
    end
    // Power word of the selected transistor follows the input live
    wr(lmr_pkg::OFS_POWER_SELECT, 8'h03);
    @(posedge i_mclk);
    i_q_power[31:24] <= 8'hFF;
    repeat (5) @(posedge i_mclk);
    wr(lmr_pkg::OFS_POWER_READING, 8'h00);
    rd(lmr_pkg::OFS_POWER_READING, d);
    check(d, 8'hFF);
    // Sign and magnitude corners of the sense registers
    sense(1'b0, 6'h3F, 1'b1, 6'h00, 8'hFF);
    sense(1'b1, 6'h00, 1'b0, 6'h3F, 8'h00);
    sense(1'b1, 6'h15, 1'b1, 6'h2A, 8'h5A);
    // Unmapped places read zero and swallow writes
    wr(8'h51, 8'hAA);
    rd(8'h51, d);
    check(d, 8'h00);
    rd(8'h4A, d);
    check(d, 8'h00);
    rd(lmr_pkg::OFS_LOW_BATTERY, d);
    check(d, 8'h00);
    // Reset in mid-run brings the settings back to their defaults
    wr(lmr_pkg::OFS_LOW_BATTERY, 8'h2A);
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    rd(lmr_pkg::OFS_LOW_BATTERY, d);
    check(d, 8'h10);
    rd(lmr_pkg::OFS_POWER_SELECT, d);
    check(d, 8'h00);
    end_sim();
  end
endmodule // tb

`default_nettype wire
